/* verilog/uart_rx_pkg.sv */
package uart_rx_pkg;

    // Oversamples per bit in each speed
    localparam logic [4:0] SAMPLES_NORMAL    = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE    = 5'h08;
    // First of the three centre voting samples
    localparam logic [4:0] FIRST_VOTE_NORMAL = 5'h08;
    localparam logic [4:0] FIRST_VOTE_DOUBLE = 5'h04;
    // Number given to the first low sample after the falling edge
    localparam logic [4:0] FIRST_LOW_SAMPLE  = 5'h01;

    // Field widths
    localparam int DIVISOR_WIDTH = 12;
    localparam int PAYLOAD_WIDTH = 9;
    localparam int SLOT_WIDTH    = 10;

    // Reset values
    localparam logic [11:0] DIVISOR_RESET = 12'h000;
    localparam logic        LINE_IDLE     = 1'b1;

    // System clock
    localparam int CLOCK_PERIOD_NS = 20;

    // Receiver states
    typedef enum logic [1:0] {
        IDLE,
        RECEIVE,
        DELIVER
    } rx_state_e;

    // One received frame as handed to the user side
    typedef struct packed {
        logic [8:0] payload;       // Data bits, unused upper bits zero
        logic       parity_bit;    // Received parity bit, zero if none
        logic       framing_error; // Stop bit resolved to zero
    } rx_word_s;

endpackage

/* verilog/line_synchroniser.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for the asynchronous receive line
module line_synchroniser (
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_async_line,
    output logic      o_sync_line
);
    import uart_rx_pkg::*;

    logic stage_one_reg;   // Metastable stage, read only by stage two
    logic stage_two_reg;   // Settled copy

    // Both stages reset to the idle line level
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            stage_one_reg <= LINE_IDLE;
            stage_two_reg <= LINE_IDLE;
        end else begin
            stage_one_reg <= i_async_line;
            stage_two_reg <= stage_one_reg;
        end
    end

    assign o_sync_line = stage_two_reg;

endmodule

/* verilog/word_buffer.sv */
`timescale 1ns/1ps

// Two-entry buffer for received words, valid and ready on both sides
module word_buffer (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_in_valid,
    output logic                       o_in_ready,
    input  wire uart_rx_pkg::rx_word_s i_in_word,
    output logic                       o_out_valid,
    input  wire logic                  i_out_ready,
    output uart_rx_pkg::rx_word_s      o_out_word
);
    import uart_rx_pkg::*;

    rx_word_s   entry_reg [2];  // Storage entries
    logic       write_ptr_reg;  // Next entry to fill
    logic       read_ptr_reg;   // Oldest entry
    logic [1:0] count_reg;      // Entries held
    logic       push;
    logic       pop;

    assign o_in_ready  = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_word  = entry_reg[read_ptr_reg];

    // Store an incoming word
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            entry_reg[0] <= '0;
            entry_reg[1] <= '0;
        end else if (push) begin
            entry_reg[write_ptr_reg] <= i_in_word;
        end
    end

    // Pointer and occupancy bookkeeping
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            write_ptr_reg <= 1'b0;
            read_ptr_reg  <= 1'b0;
            count_reg     <= 2'h0;
        end else begin
            if (push) begin
                write_ptr_reg <= ~write_ptr_reg;
            end
            if (pop) begin
                read_ptr_reg <= ~read_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule

/* verilog/uart_async_rx_recovery.sv */
`timescale 1ns/1ps

module uart_async_rx_recovery (
    input  wire logic                      i_clock,
    input  wire logic                      i_reset_n,
    input  wire logic                      i_rx_line,
    input  wire logic                      i_double_speed_select,
    input  wire logic [11:0]               i_baud_divisor,
    input  wire logic [3:0]                i_data_bits,
    input  wire logic                      i_parity_enable,
    output logic                           o_word_valid,
    input  wire logic                      i_word_ready,
    output uart_rx_pkg::rx_word_s          o_word,
    output logic                           o_framing_error_flag,
    output logic                           o_start_rejected,
    output logic                           o_receiving
);
    import uart_rx_pkg::*;

    // Synchronised receive line
    logic                     line_sync;
    // Oversample tick from the divider
    logic [DIVISOR_WIDTH-1:0] divider_reg;
    logic                     sample_tick;
    // Receiver state and position within the frame
    rx_state_e                state_reg;
    logic [4:0]               sample_reg;
    logic [3:0]               slot_reg;
    logic [3:0]               last_slot_reg;
    logic [3:0]               data_bits_reg;
    logic                     parity_en_reg;
    // Previous oversample of the line, for edge detection
    logic                     prev_line_reg;
    // First two voting samples of the current bit
    logic [1:0]               vote_reg;
    // Recovered data and parity bits
    logic [SLOT_WIDTH-1:0]    slots_reg;
    logic                     frame_error_reg;
    logic                     framing_flag_reg;
    logic                     reject_reg;
    // Speed dependent figures
    logic [4:0]               samples_per_bit;
    logic [4:0]               first_vote;
    logic [4:0]               last_vote;
    // Events of the current tick
    logic                     falling_edge;
    logic                     can_start;
    logic                     at_vote_end;
    logic                     majority;
    logic                     push_valid;
    logic                     push_ready;
    rx_word_s                 push_word;
    logic [PAYLOAD_WIDTH-1:0] payload;

    // Line passes through two flops before any sampling
    line_synchroniser u_sync (
        .i_clock      (i_clock),
        .i_reset_n    (i_reset_n),
        .i_async_line (i_rx_line),
        .o_sync_line  (line_sync)
    );

    // Speed select picks oversample rate and voting window
    always_comb begin
        if (i_double_speed_select) begin
            samples_per_bit = SAMPLES_DOUBLE;
            first_vote      = FIRST_VOTE_DOUBLE;
        end else begin
            samples_per_bit = SAMPLES_NORMAL;
            first_vote      = FIRST_VOTE_NORMAL;
        end
        last_vote = first_vote + 5'h02;
    end

    // Divider gives one oversample tick every divisor plus one clocks
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            divider_reg <= DIVISOR_RESET;
        end else if (divider_reg == '0) begin
            divider_reg <= i_baud_divisor;
        end else begin
            divider_reg <= divider_reg - 12'h001;
        end
    end

    assign sample_tick = (divider_reg == '0);

    // Falling edge seen between two oversamples
    assign falling_edge = sample_tick && prev_line_reg && !line_sync;
    // Search is open when idle or while the last word is being taken
    assign can_start    = (state_reg == IDLE) ||
                          ((state_reg == DELIVER) && push_ready);
    // Last of the three centre samples of the current bit
    assign at_vote_end  = sample_tick && (state_reg == RECEIVE) &&
                          (sample_reg == last_vote);
    // Two of three decide the bit
    assign majority     = (vote_reg[0] & vote_reg[1]) |
                          (vote_reg[0] & line_sync) |
                          (vote_reg[1] & line_sync);

    // Remember the line at every oversample
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            prev_line_reg <= LINE_IDLE;
        end else if (sample_tick) begin
            prev_line_reg <= line_sync;
        end
    end

    // Receiver sequence
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_reg <= IDLE;
        end else begin
            case (state_reg)
                // Wait for a falling edge
                IDLE: begin
                    if (falling_edge) begin
                        state_reg <= RECEIVE;
                    end
                end
                // Step through oversamples of each bit
                RECEIVE: begin
                    if (at_vote_end && (slot_reg == 4'h0) && majority) begin
                        state_reg <= IDLE;
                    end else if (at_vote_end && (slot_reg == last_slot_reg)) begin
                        state_reg <= DELIVER;
                    end
                end
                // Hand the word over; a new start may begin at once
                DELIVER: begin
                    if (push_ready && falling_edge) begin
                        state_reg <= RECEIVE;
                    end else if (push_ready) begin
                        state_reg <= IDLE;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    // Oversample number and bit slot within the frame
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            sample_reg <= 5'h00;
            slot_reg   <= 4'h0;
        end else if (can_start && falling_edge) begin
            // This tick was sample one, so the next tick is sample two
            sample_reg <= FIRST_LOW_SAMPLE + 5'h01;
            slot_reg   <= 4'h0;
        end else if (sample_tick && (state_reg == RECEIVE)) begin
            if (sample_reg == samples_per_bit) begin
                // Last oversample of the bit, wrap to sample one of the next bit
                sample_reg <= FIRST_LOW_SAMPLE;
                slot_reg   <= slot_reg + 4'h1;
            end else begin
                sample_reg <= sample_reg + 5'h01;
            end
        end
    end

    // Frame shape is held for the whole frame
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            data_bits_reg <= 4'h0;
            parity_en_reg <= 1'b0;
            last_slot_reg <= 4'h0;
        end else if (can_start && falling_edge) begin
            data_bits_reg <= i_data_bits;
            parity_en_reg <= i_parity_enable;
            // Start, data, optional parity, then the first stop bit
            last_slot_reg <= i_data_bits + {3'h0, i_parity_enable} + 4'h1;
        end
    end

    // Capture the first two centre samples
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            vote_reg <= 2'h3;
        end else if (sample_tick && (state_reg == RECEIVE)) begin
            if (sample_reg == first_vote) begin
                vote_reg[0] <= line_sync;
            end else if (sample_reg == first_vote + 5'h01) begin
                vote_reg[1] <= line_sync;
            end
        end
    end

    // Store each voted data or parity bit by slot
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            slots_reg <= '0;
        end else if (can_start && falling_edge) begin
            slots_reg <= '0;
        end else if (at_vote_end && (slot_reg != 4'h0) && (slot_reg != last_slot_reg)) begin
            slots_reg[slot_reg - 4'h1] <= majority;
        end
    end

    // Stop bit decides the frame error; later stop bits are never looked at
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            frame_error_reg  <= 1'b0;
            framing_flag_reg <= 1'b0;
        end else if (at_vote_end && (slot_reg == last_slot_reg)) begin
            frame_error_reg  <= !majority;
            framing_flag_reg <= !majority;
        end
    end

    // One pulse for each start rejected as noise
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= at_vote_end && (slot_reg == 4'h0) && majority;
        end
    end

    // Keep only the configured number of data bits
    for (genvar bit_i = 0; bit_i < PAYLOAD_WIDTH; bit_i++) begin : g_payload
        assign payload[bit_i] = slots_reg[bit_i] && (bit_i < data_bits_reg);
    end

    // Word offered to the buffer
    always_comb begin
        push_word               = '0;
        push_word.payload       = payload;
        push_word.parity_bit    = parity_en_reg && slots_reg[data_bits_reg];
        push_word.framing_error = frame_error_reg;
    end

    assign push_valid = (state_reg == DELIVER);

    // A stalled receiver holds the word here and searches no new start
    word_buffer u_buffer (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push_valid),
        .o_in_ready  (push_ready),
        .i_in_word   (push_word),
        .o_out_valid (o_word_valid),
        .i_out_ready (i_word_ready),
        .o_out_word  (o_word)
    );

    // Status outputs
    assign o_framing_error_flag = framing_flag_reg;
    assign o_start_rejected     = reject_reg;
    assign o_receiving          = (state_reg == RECEIVE);

endmodule

/* tb/uart_rx_recovery_props.sv */
`timescale 1ns/1ps

// Port-level checks of start detection, bit timing and the stop-bit flag
module uart_rx_recovery_props (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_rx_line,
    input  wire logic                  i_double_speed_select,
    input  wire logic [11:0]           i_baud_divisor,
    input  wire logic [3:0]            i_data_bits,
    input  wire logic                  i_parity_enable,
    input  wire logic                  o_word_valid,
    input  wire logic                  i_word_ready,
    input  wire uart_rx_pkg::rx_word_s o_word,
    input  wire logic                  o_framing_error_flag,
    input  wire logic                  o_start_rejected,
    input  wire logic                  o_receiving
);
    import uart_rx_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    logic [8:0] busy_reg;  // Cycles spent receiving
    logic [3:0] idle_reg;  // Idle cycles, saturating
    logic [8:0] frame_len; // Expected receive length in cycles
    logic       fast;      // One oversample tick per clock

    assign fast = (i_baud_divisor == 12'h000);
    // Start plus data plus parity bits, then up to the last stop vote
    assign frame_len = (9'(i_data_bits) + 9'(i_parity_enable) + 9'h001)
                     * (i_double_speed_select ? 9'h008 : 9'h010)
                     + (i_double_speed_select ? 9'h005 : 9'h009);

    // Counts how long the receiver is busy and how long it has been idle
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            busy_reg <= '0;
            idle_reg <= '0;
        end else begin
            busy_reg <= o_receiving ? busy_reg + 9'h001 : 9'h000;
            idle_reg <= o_receiving ? 4'h0 : (idle_reg == 4'hf ? idle_reg : idle_reg + 4'h1);
        end
    end

    property p_start_detect;
        $fell(i_rx_line) && fast && idle_reg == 4'hf && !o_word_valid |-> ##[1:5] o_receiving;
    endproperty
    a_start_detect: assert property (p_start_detect) else $error("idle fall not taken");
    property p_sync_delay;
        $fell(i_rx_line) && !o_receiving |=> !o_receiving;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("line not synchronised");
    property p_reject_normal;
        o_start_rejected && fast && !i_double_speed_select
            |-> $past(o_receiving, 9) && !$past(o_receiving, 10);
    endproperty
    a_reject_normal: assert property (p_reject_normal) else $error("normal vote late");
    property p_reject_double;
        o_start_rejected && fast && i_double_speed_select
            |-> $past(o_receiving, 5) && !$past(o_receiving, 6);
    endproperty
    a_reject_double: assert property (p_reject_double) else $error("double vote late");
    property p_reject_pulse;
        o_start_rejected |=> !o_start_rejected;
    endproperty
    a_reject_pulse: assert property (p_reject_pulse) else $error("reject not a pulse");
    property p_reject_ends;
        o_start_rejected |=> !o_receiving;
    endproperty
    a_reject_ends: assert property (p_reject_ends) else $error("reject keeps busy");
    property p_frame_len;
        $fell(o_receiving) && fast && busy_reg > 9'h01e
            |-> busy_reg == frame_len;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length off");
    property p_flag_word;
        $rose(o_word_valid) |-> o_word.framing_error == o_framing_error_flag;
    endproperty
    a_flag_word: assert property (p_flag_word) else $error("flag and word differ");

    c_reject: cover property (o_start_rejected);
    c_error: cover property ($rose(o_word_valid) && o_word.framing_error);
    c_stall: cover property (o_word_valid && !i_word_ready ##1 o_word_valid);
endmodule

bind uart_async_rx_recovery uart_rx_recovery_props i_props (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_rx_line(i_rx_line),
    .i_double_speed_select(i_double_speed_select), .i_baud_divisor(i_baud_divisor),
    .i_data_bits(i_data_bits), .i_parity_enable(i_parity_enable),
    .o_word_valid(o_word_valid), .i_word_ready(i_word_ready), .o_word(o_word),
    .o_framing_error_flag(o_framing_error_flag), .o_start_rejected(o_start_rejected),
    .o_receiving(o_receiving));

/* tb/serial_sender.sv */
`timescale 1ns/1ps

// Remote sender driving the receive line, idle high between frames
module serial_sender (
    input  wire logic i_clock,
    output logic      o_line
);
    initial o_line = 1'b1;  // Idle level from time zero

    // One frame: start, bits LSB first, one stop; glitch flips one clock per bit
    task automatic send(input logic [9:0] bits, input int n_bits, input int spb,
                        input logic stop_val, input int stop_len, input int glitch);
        int i;
        int k;
        for (i = -1; i <= n_bits; i++) begin
            for (k = 1; k <= ((i == n_bits) ? stop_len : spb); k++) begin
                @(negedge i_clock);
                // Exact bit period keeps the rate error at zero
                o_line = ((i < 0) ? 1'b0 : (i == n_bits) ? stop_val : bits[i]) ^ (k == glitch);
            end
        end
        @(negedge i_clock);
        o_line = 1'b1;
    endtask

    // Short low spike that must not be taken as a start
    task automatic noise(input int len);
        @(negedge i_clock);
        o_line = 1'b0;
        repeat (len) @(negedge i_clock);
        o_line = 1'b1;
    endtask
endmodule

/* tb/uart_async_rx_recovery_tb.sv */
`timescale 1ns/1ps

`define CHECK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end

// Self-checking bench for the receive front end
module uart_async_rx_recovery_tb;
    import uart_rx_pkg::*;

    logic       i_clock;               // 50 MHz system clock
    logic       i_reset_n;             // Synchronous reset, active low
    logic       rx_line;               // Line from the remote sender
    logic       i_double_speed_select; // Eight samples per bit when high
    logic [3:0] i_data_bits;           // Payload width
    logic       i_parity_enable;       // Frame carries a parity bit
    logic       i_word_ready;          // User accepts a word
    logic       o_word_valid;          // Word waiting
    rx_word_s   o_word;                // Head word
    logic       o_framing_error_flag;  // Last stop bit voted low
    logic       o_start_rejected;      // Start taken as noise
    logic       o_receiving;           // Frame in progress
    int         mismatches;            // Failed comparisons
    int         n_compared;            // All comparisons

    always #10 i_clock = ~i_clock;

    uart_async_rx_recovery i_dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_rx_line(rx_line),
        .i_double_speed_select(i_double_speed_select), .i_baud_divisor(12'h000),
        .i_data_bits(i_data_bits), .i_parity_enable(i_parity_enable),
        .o_word_valid(o_word_valid), .i_word_ready(i_word_ready), .o_word(o_word),
        .o_framing_error_flag(o_framing_error_flag), .o_start_rejected(o_start_rejected),
        .o_receiving(o_receiving));

    serial_sender i_sender (.i_clock(i_clock), .o_line(rx_line));

    function automatic rx_word_s mk(input logic [8:0] p, input logic par, input logic fe);
        mk = '{payload: p, parity_bit: par, framing_error: fe};
    endfunction

    // Waits a bounded time for a word, compares it, then takes it
    task automatic take(input rx_word_s exp);
        int t;
        t = 0;
        while (o_word_valid !== 1'b1 && t < 400) begin
            @(negedge i_clock);
            t++;
        end
        `CHECK("word", exp, o_word)
        i_word_ready = 1'b1;
        @(negedge i_clock);
        i_word_ready = 1'b0;
    endtask

    // Normal speed frame with a one-sample glitch at every bit centre
    task automatic t_normal();
        i_double_speed_select = 1'b0;
        i_data_bits = 4'h8;
        i_parity_enable = 1'b0;
        i_sender.send(10'h0a5, 8, 16, 1'b1, 16, 9);
        take(mk(9'h0a5, 1'b0, 1'b0));
        `CHECK("flag", 1'b0, o_framing_error_flag)
    endtask

    // Double speed, nine bits with parity, then five bits
    task automatic t_double();
        i_double_speed_select = 1'b1;
        i_data_bits = 4'h9;
        i_parity_enable = 1'b1;
        i_sender.send(10'h3c6, 10, 8, 1'b1, 8, 5);
        take(mk(9'h1c6, 1'b1, 1'b0));
        i_data_bits = 4'h5;
        i_parity_enable = 1'b0;
        i_sender.send(10'h013, 5, 8, 1'b1, 8, 5);
        take(mk(9'h013, 1'b0, 1'b0));
    endtask

    // Stop bit sent low gives an error word and flag
    task automatic t_frame_error();
        i_double_speed_select = 1'b0;
        i_data_bits = 4'h8;
        i_sender.send(10'h03c, 8, 16, 1'b0, 16, 0);
        take(mk(9'h03c, 1'b0, 1'b1));
        `CHECK("flag", 1'b1, o_framing_error_flag)
    endtask

    // Short spikes in both speeds are rejected, no word follows
    task automatic t_noise(input logic dss, input int len);
        logic seen;
        seen = 1'b0;
        i_double_speed_select = dss;
        i_sender.noise(len);
        repeat (30) begin
            @(negedge i_clock);
            seen = seen | o_start_rejected;
        end
        `CHECK("reject", 1'b1, seen)
        `CHECK("valid", 1'b0, o_word_valid)
    endtask

    // Three frames with short stops while the user stalls, then drained
    task automatic t_stall();
        i_double_speed_select = 1'b0;
        i_data_bits = 4'h8;
        i_sender.send(10'h011, 8, 16, 1'b1, 9, 0);
        i_sender.send(10'h0e2, 8, 16, 1'b1, 9, 0);
        i_sender.send(10'h07f, 8, 16, 1'b1, 9, 0);
        repeat (4) @(negedge i_clock);
        take(mk(9'h011, 1'b0, 1'b0));
        take(mk(9'h0e2, 1'b0, 1'b0));
        take(mk(9'h07f, 1'b0, 1'b0));
        `CHECK("empty", 1'b0, o_word_valid)
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence after a 16-cycle reset
    initial begin
        i_clock = 1'b0;
        i_reset_n = 1'b0;
        i_double_speed_select = 1'b0;
        i_data_bits = 4'h8;
        i_parity_enable = 1'b0;
        i_word_ready = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(negedge i_clock);
        i_reset_n = 1'b1;
        repeat (20) @(negedge i_clock);
        t_normal();
        t_double();
        t_frame_error();
        t_noise(1'b0, 5);
        t_noise(1'b1, 3);
        t_normal();
        t_stall();
        print_verdict();
    end

    // Watchdog well beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        print_verdict();
    end
endmodule
